// *** core/alu_pkg.sv ***
/*
 * shared types and constants of the accumulator datapath: opcodes,
 * flag layout, reset values and the adder function.
 * assumes the surrounding core decodes instructions into op_t.
 */
package alu_pkg;
    // ----------------------------------------
    // sizes and reset values
    // ----------------------------------------
    localparam int ADDR_W = 10;              // whole data memory, all sections
    localparam int BANK_W = 2;               // section select for plain ops
    localparam int PROG_W_DEF = 14;          // program memory word address
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] CLR_VAL = 8'h00;  // cleared byte
    localparam logic [7:0] ONE_VAL = 8'h01;  // step of inc and dec
    localparam logic [7:0] ADJ_LO = 8'h06;   // decimal low nibble step
    localparam logic [7:0] ADJ_HI = 8'h60;   // decimal high nibble step
    localparam logic [3:0] NIB_MAX = 4'h9;   // largest decimal digit
    // ----------------------------------------
    // operations
    // ----------------------------------------
    typedef enum logic [4:0] {
        op_nop, subtract_into_mem, subtract_imm, nibble_exchange_mem,
        nibble_exchange_to_acc, skip_on_zero_mem, skip_zero_copy_to_acc,
        skip_on_bit_zero, table_read_paged, table_read_last_page,
        table_read_preinc_paged, table_read_preinc_last_page,
        xor_to_acc, xor_into_mem, xor_imm, ext_add_carry_to_acc,
        ext_add_carry_into_mem, ext_sum_to_acc, ext_sum_into_mem,
        ext_and_to_acc, ext_and_into_mem, ext_zero_mem, ext_zero_bit,
        ext_invert_mem, ext_invert_to_acc, ext_decimal_adjust,
        ext_decrement_mem, ext_decrement_to_acc, ext_increment_mem,
        ext_increment_to_acc
    } op_t;
    typedef struct packed {
        op_t op;                    // operation to run
        logic [7:0] imm;            // constant from the instruction word
        logic [2:0] bit_sel;        // selected bit
        logic [ADDR_W-1:0] addr;    // byte address
    } instr_t;
    typedef struct packed {
        logic sign_wrap_flag;
        logic z;
        logic aux_carry_flag;
        logic c;
        logic signed_carry_flag;
        logic chained_zero_flag;
    } flags_t;
    localparam flags_t FLAGS_RST = '0;
    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic ac;
        logic ov;
        logic sc;
    } alu_res_t;
    // ----------------------------------------
    // 8-bit adder with flags, result wraps modulo 256
    // ----------------------------------------
    function automatic alu_res_t add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
        alu_res_t r;
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r.res = s[7:0];
        r.c = s[8];
        r.ac = n[4];
        r.ov = (a[7] == b[7]) && (s[7] != a[7]);
        r.sc = r.ov ^ s[7];   // true sign of the unbounded result
        return r;
    endfunction
endpackage

// *** core/acc_alu.sv ***
/*
 * accumulator datapath of the core: executes one decoded operation
 * per accepted request, keeps accumulator, flags and table pointers.
 * assumes the core presents the addressed byte on mem_rdata in the
 * same cycle as the request, returns prog_word for prog_addr in the
 * same cycle it is driven, and inserts a dummy cycle on skip.
 */
// Function
// - subtract into memory, six flags updated
// - subtraction carry is not-borrow
// - subtract constant into accumulator, six flags
// - nibble exchange in memory, flags kept
// - nibble exchange into accumulator, memory kept
// - zero byte written back, skips next
// - copy byte to accumulator, skip if zero
// - skip when selected bit is zero
// - paged table read splits word
// - last page table read by low pointer
// - increment low pointer then paged read
// - increment low pointer then last-page read
// - exclusive-or updates zero flag only
// - extended ops reach every memory section
// - add with carry, chained-zero kept
// - add without carry, five flags
// - and updates zero flag only
// - clear byte or bit, no flags
// - complement to memory or accumulator, zero flag
// - decimal adjust adds 00/06/60/66 into memory
// - decimal adjust touches carry only
// - increment or decrement, zero flag
`timescale 1ns/1ps
module acc_alu #(
    parameter int PROG_W = alu_pkg::PROG_W_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request from the sequencer
    input wire logic op_valid,
    input wire alu_pkg::instr_t instr,
    input wire logic [alu_pkg::BANK_W-1:0] bank_sel,
    output logic busy,
    output logic skip,
    // data memory
    input wire logic [7:0] mem_rdata,
    output logic mem_we,
    output logic [alu_pkg::ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_wdata,
    // program memory for table reads
    output logic [PROG_W-1:0] prog_addr,
    input wire logic [15:0] prog_word,
    // table pointer loads from software
    input wire logic ptr_low_we,
    input wire logic ptr_high_we,
    input wire logic [7:0] ptr_wdata,
    // state seen by the core
    output logic [7:0] acc,
    output alu_pkg::flags_t flags,
    output logic [7:0] table_ptr_low,
    output logic [7:0] table_ptr_high,
    output logic [7:0] table_read_high_byte
);
    import alu_pkg::*;

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    // the pointer pair spans 16 bits; last page needs at least 9
    if (PROG_W < 9 || PROG_W > 16) begin : g_bad_prog_w
        $error("PROG_W must lie between 9 and 16");
    end

    typedef enum logic {st_idle, st_table} state_t;

    // ----------------------------------------
    // state
    // ----------------------------------------
    state_t state_reg, state_next;          // table read in flight
    logic [7:0] acc_reg, acc_next;
    flags_t flags_reg, flags_next;
    logic mem_we_reg, mem_we_next;          // one-cycle write strobe
    logic [ADDR_W-1:0] mem_addr_reg, mem_addr_next;
    logic [7:0] mem_wdata_reg, mem_wdata_next;
    logic skip_reg, skip_next;              // one-cycle skip request
    logic [PROG_W-1:0] prog_addr_reg, prog_addr_next;
    logic [7:0] ptr_lo_reg, ptr_lo_next;
    logic [7:0] ptr_hi_reg, ptr_hi_next;
    logic [7:0] table_read_high_byte_reg, table_read_high_byte_next;

    // ----------------------------------------
    // combinational helpers
    // ----------------------------------------
    logic go;                 // request accepted this cycle
    logic [ADDR_W-1:0] eff_addr;
    logic [7:0] m;            // addressed byte
    alu_res_t sub_r, add_r, adc_r;
    logic [7:0] ptr_inc;
    logic [7:0] adj;
    logic [8:0] daa_sum;

    assign go = op_valid && (state_reg == st_idle);
    assign m = mem_rdata;
    assign ptr_inc = ptr_lo_reg + ONE_VAL;
    // subtraction is addition of the inverse plus one, so carry out
    // reads as not-borrow without a separate comparator
    assign sub_r = add8(acc_reg, ~((instr.op == subtract_imm) ? instr.imm : m),
                        1'b1);
    assign add_r = add8(acc_reg, m, 1'b0);
    assign adc_r = add8(acc_reg, m, flags_reg.c);

    // extended ops take the full address, plain ops the current section
    always_comb begin
        eff_addr = {bank_sel, instr.addr[7:0]};
        if (instr.op >= ext_add_carry_to_acc) begin
            eff_addr = instr.addr;
        end
    end

    // decimal adjust step chosen per nibble
    always_comb begin
        adj = 8'h00;
        if (acc_reg[3:0] > NIB_MAX || flags_reg.aux_carry_flag) begin
            adj = adj | ADJ_LO;
        end
        if (acc_reg[7:4] > NIB_MAX || flags_reg.c) begin
            adj = adj | ADJ_HI;
        end
        daa_sum = {1'b0, acc_reg} + {1'b0, adj};
    end

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        acc_next = acc_reg;
        flags_next = flags_reg;
        mem_we_next = 1'b0;
        mem_addr_next = mem_addr_reg;
        mem_wdata_next = mem_wdata_reg;
        skip_next = 1'b0;
        prog_addr_next = prog_addr_reg;
        ptr_lo_next = ptr_lo_reg;
        ptr_hi_next = ptr_hi_reg;
        table_read_high_byte_next = table_read_high_byte_reg;
        // software pointer loads; an instruction's increment wins below
        if (ptr_low_we) begin
            ptr_lo_next = ptr_wdata;
        end
        if (ptr_high_we) begin
            ptr_hi_next = ptr_wdata;
        end
        if (state_reg == st_table) begin
            // second cycle: program word has arrived
            mem_we_next = 1'b1;
            mem_wdata_next = prog_word[7:0];
            table_read_high_byte_next = prog_word[15:8];
            state_next = st_idle;
        end else if (go) begin
            mem_addr_next = eff_addr;
            unique case (instr.op)
                subtract_into_mem: begin
                    mem_we_next = 1'b1;
                    mem_wdata_next = sub_r.res;
                    flags_next = '{sub_r.ov, sub_r.res == 8'h00, sub_r.ac,
                                   sub_r.c, sub_r.sc, sub_r.res == 8'h00};
                end
                subtract_imm: begin
                    acc_next = sub_r.res;
                    flags_next = '{sub_r.ov, sub_r.res == 8'h00, sub_r.ac,
                                   sub_r.c, sub_r.sc, sub_r.res == 8'h00};
                end
                nibble_exchange_mem: begin
                    mem_we_next = 1'b1;
                    mem_wdata_next = {m[3:0], m[7:4]};
                end
                nibble_exchange_to_acc: begin
                    acc_next = {m[3:0], m[7:4]};
                end
                skip_on_zero_mem: begin
                    // value read out is written back unchanged
                    mem_we_next = 1'b1;
                    mem_wdata_next = m;
                    skip_next = (m == 8'h00);
                end
                skip_zero_copy_to_acc: begin
                    acc_next = m;
                    skip_next = (m == 8'h00);
                end
                skip_on_bit_zero: begin
                    skip_next = !m[instr.bit_sel];
                end
                table_read_paged: begin
                    prog_addr_next = PROG_W'({ptr_hi_reg, ptr_lo_reg});
                    state_next = st_table;
                end
                table_read_last_page: begin
                    prog_addr_next = {{(PROG_W-8){1'b1}}, ptr_lo_reg};
                    state_next = st_table;
                end
                table_read_preinc_paged: begin
                    ptr_lo_next = ptr_inc;
                    prog_addr_next = PROG_W'({ptr_hi_reg, ptr_inc});
                    state_next = st_table;
                end
                table_read_preinc_last_page: begin
                    ptr_lo_next = ptr_inc;
                    prog_addr_next = {{(PROG_W-8){1'b1}}, ptr_inc};
                    state_next = st_table;
                end
                xor_to_acc, xor_imm: begin
                    acc_next = acc_reg ^ ((instr.op == xor_imm) ? instr.imm : m);
                    flags_next.z = (acc_next == 8'h00);
                end
                xor_into_mem: begin
                    mem_we_next = 1'b1;
                    mem_wdata_next = acc_reg ^ m;
                    flags_next.z = (mem_wdata_next == 8'h00);
                end
                ext_add_carry_to_acc, ext_add_carry_into_mem,
                ext_sum_to_acc, ext_sum_into_mem: begin
                    // chained-zero stays as it was
                    flags_next.sign_wrap_flag = (instr.op <= ext_add_carry_into_mem)
                        ? adc_r.ov : add_r.ov;
                    if (instr.op <= ext_add_carry_into_mem) begin
                        flags_next.aux_carry_flag = adc_r.ac;
                        flags_next.c = adc_r.c;
                        flags_next.signed_carry_flag = adc_r.sc;
                        flags_next.z = (adc_r.res == 8'h00);
                        acc_next = (instr.op == ext_add_carry_to_acc) ? adc_r.res : acc_reg;
                        mem_wdata_next = adc_r.res;
                    end else begin
                        flags_next.aux_carry_flag = add_r.ac;
                        flags_next.c = add_r.c;
                        flags_next.signed_carry_flag = add_r.sc;
                        flags_next.z = (add_r.res == 8'h00);
                        acc_next = (instr.op == ext_sum_to_acc) ? add_r.res : acc_reg;
                        mem_wdata_next = add_r.res;
                    end
                    mem_we_next = (instr.op == ext_add_carry_into_mem)
                        || (instr.op == ext_sum_into_mem);
                end
                ext_and_to_acc: begin
                    acc_next = acc_reg & m;
                    flags_next.z = (acc_next == 8'h00);
                end
                ext_and_into_mem: begin
                    mem_we_next = 1'b1;
                    mem_wdata_next = acc_reg & m;
                    flags_next.z = (mem_wdata_next == 8'h00);
                end
                ext_zero_mem: begin
                    mem_we_next = 1'b1;
                    mem_wdata_next = CLR_VAL;
                end
                ext_zero_bit: begin
                    mem_we_next = 1'b1;
                    mem_wdata_next = m & ~(ONE_VAL << instr.bit_sel);
                end
                ext_invert_mem: begin
                    mem_we_next = 1'b1;
                    mem_wdata_next = ~m;
                    flags_next.z = (m == 8'hFF);
                end
                ext_invert_to_acc: begin
                    acc_next = ~m;
                    flags_next.z = (m == 8'hFF);
                end
                ext_decimal_adjust: begin
                    // carry only ever sets, so a multi-byte sum keeps it
                    mem_we_next = 1'b1;
                    mem_wdata_next = daa_sum[7:0];
                    flags_next.c = flags_reg.c | daa_sum[8];
                end
                ext_decrement_mem, ext_decrement_to_acc,
                ext_increment_mem, ext_increment_to_acc: begin
                    mem_wdata_next = (instr.op <= ext_decrement_to_acc)
                        ? m - ONE_VAL : m + ONE_VAL;
                    mem_we_next = (instr.op == ext_decrement_mem)
                        || (instr.op == ext_increment_mem);
                    if (!mem_we_next) begin
                        acc_next = mem_wdata_next;
                        mem_wdata_next = mem_wdata_reg;
                    end
                    flags_next.z = (mem_we_next ? mem_wdata_next : acc_next) == 8'h00;
                end
                default: begin
                    // op_nop leaves everything but mem_addr, mem_we and skip as it stands
                end
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= st_idle;
            acc_reg <= ACC_RST;
            flags_reg <= FLAGS_RST;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= '0;
            mem_wdata_reg <= CLR_VAL;
            skip_reg <= 1'b0;
            prog_addr_reg <= '0;
            ptr_lo_reg <= PTR_RST;
            ptr_hi_reg <= PTR_RST;
            table_read_high_byte_reg <= CLR_VAL;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            flags_reg <= flags_next;
            mem_we_reg <= mem_we_next;
            mem_addr_reg <= mem_addr_next;
            mem_wdata_reg <= mem_wdata_next;
            skip_reg <= skip_next;
            prog_addr_reg <= prog_addr_next;
            ptr_lo_reg <= ptr_lo_next;
            ptr_hi_reg <= ptr_hi_next;
            table_read_high_byte_reg <= table_read_high_byte_next;
        end
    end

    assign busy = (state_reg == st_table);
    assign skip = skip_reg;
    assign mem_we = mem_we_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;
    assign prog_addr = prog_addr_reg;
    assign acc = acc_reg;
    assign flags = flags_reg;
    assign table_ptr_low = ptr_lo_reg;
    assign table_ptr_high = ptr_hi_reg;
    assign table_read_high_byte = table_read_high_byte_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_sub_mem;
        @(posedge clk) disable iff (rst)
        go && instr.op == subtract_into_mem |=> mem_we_reg
            && mem_wdata_reg == 8'($past(acc_reg) - $past(mem_rdata));
    endproperty
    a_sub_mem: assert property (p_sub_mem) else $error("subtract to memory wrong");
    property p_sub_carry;
        @(posedge clk) disable iff (rst)
        go && instr.op == subtract_imm |=> flags_reg.c == ($past(acc_reg) >= $past(instr.imm));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("borrow flag wrong");
    property p_swap;
        @(posedge clk) disable iff (rst)
        go && instr.op == nibble_exchange_mem |=> mem_we_reg
            && mem_wdata_reg == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} && $stable(flags_reg);
    endproperty
    a_swap: assert property (p_swap) else $error("nibble exchange wrong");
    property p_nibble_exchange_to_acc;
        @(posedge clk) disable iff (rst)
        go && instr.op == nibble_exchange_to_acc |=> !mem_we_reg
            && acc_reg == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])};
    endproperty
    a_nibble_exchange_to_acc: assert property (p_nibble_exchange_to_acc) else $error("exchange to acc wrong");
    property p_skip_zero;
        @(posedge clk) disable iff (rst)
        go && instr.op == skip_on_zero_mem |=> skip_reg == ($past(mem_rdata) == 8'h00)
            && mem_we_reg && mem_wdata_reg == $past(mem_rdata) ##1 ($past(go) || !skip_reg);
    endproperty
    a_skip_zero: assert property (p_skip_zero) else $error("skip on zero wrong");
    property p_table;
        @(posedge clk) disable iff (rst)
        go && instr.op == table_read_paged |=> busy && !mem_we_reg ##1 mem_we_reg
            && !busy && table_read_high_byte_reg == $past(prog_word[15:8]);
    endproperty
    a_table: assert property (p_table) else $error("table read wrong");
    property p_preinc;
        @(posedge clk) disable iff (rst)
        go && instr.op == table_read_preinc_paged |=> ptr_lo_reg == 8'($past(ptr_lo_reg) + 8'h01)
            && prog_addr_reg[7:0] == ptr_lo_reg;
    endproperty
    a_preinc: assert property (p_preinc) else $error("pointer increment wrong");
    property p_xor_flags;
        @(posedge clk) disable iff (rst)
        go && instr.op == xor_to_acc |=> flags_reg.c == $past(flags_reg.c)
            && flags_reg.z == (acc_reg == 8'h00);
    endproperty
    a_xor_flags: assert property (p_xor_flags) else $error("xor flags wrong");
    property p_clear;
        @(posedge clk) disable iff (rst)
        go && instr.op == ext_zero_mem |=> mem_we_reg && mem_wdata_reg == 8'h00 && $stable(flags_reg);
    endproperty
    a_clear: assert property (p_clear) else $error("clear wrong");
    property p_inc_wrap;
        @(posedge clk) disable iff (rst)
        go && instr.op == ext_increment_to_acc && mem_rdata == 8'hFF |=> acc_reg == 8'h00
            && flags_reg.z && !mem_we_reg;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap) else $error("increment wrap wrong");
endmodule

// *** test/acc_alu_bench.sv ***
/*
 * self-checking bench of the accumulator datapath: a table of chained
 * operations, then table reads and resets written out by hand.
 * assumes alu_pkg and acc_alu are compiled first.
 */
`timescale 1ns/1ps
module acc_alu_bench;
    import alu_pkg::*;
    // ----------------------------------------
    // signals and table rows
    // ----------------------------------------
    typedef struct packed {
        op_t op;
        logic [7:0] imm, rd, acc;  // imm low bits double as bit select
        logic we;
        logic [7:0] wd;
        logic [5:0] fl;
        logic sk;
    } row_t;
    logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0, busy, skip, mem_we;
    logic ptr_low_we = 1'b0, ptr_high_we = 1'b0;
    logic [7:0] ptr_wdata = 8'h00, mem_rdata = 8'h00, mem_wdata, acc, tpl, tph, tbh;
    logic [1:0] bank_sel = 2'h1;  // plain ops land in section one
    logic [ADDR_W-1:0] mem_addr, a;
    logic [13:0] prog_addr;
    logic [15:0] prog_word = 16'h0000;
    instr_t instr = '0;
    flags_t flags;
    int miscompares = 0, compares = 0, cyc = 0;
    // acc and flags chain from row to row, starting from reset values
    row_t rows [32] = '{
        '{skip_zero_copy_to_acc, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 6'h00, 1'b1},
        '{skip_zero_copy_to_acc, 8'h00, 8'h5A, 8'h5A, 1'b0, 8'h00, 6'h00, 1'b0},
        '{subtract_into_mem, 8'h00, 8'h6B, 8'h5A, 1'b1, 8'hEF, 6'h02, 1'b0},
        '{subtract_imm, 8'h5A, 8'h00, 8'h00, 1'b0, 8'h00, 6'h1D, 1'b0},
        '{subtract_imm, 8'h01, 8'h00, 8'hFF, 1'b0, 8'h00, 6'h02, 1'b0},
        '{nibble_exchange_mem, 8'h00, 8'h3C, 8'hFF, 1'b1, 8'hC3, 6'h02, 1'b0},
        '{nibble_exchange_to_acc, 8'h00, 8'hA5, 8'h5A, 1'b0, 8'h00, 6'h02, 1'b0},
        '{xor_to_acc, 8'h00, 8'h5A, 8'h00, 1'b0, 8'h00, 6'h12, 1'b0},
        '{xor_imm, 8'hF0, 8'h00, 8'hF0, 1'b0, 8'h00, 6'h02, 1'b0},
        '{xor_into_mem, 8'h00, 8'hF0, 8'hF0, 1'b1, 8'h00, 6'h12, 1'b0},
        '{ext_sum_to_acc, 8'h00, 8'h90, 8'h80, 1'b0, 8'h00, 6'h06, 1'b0},
        '{ext_add_carry_to_acc, 8'h00, 8'h7F, 8'h00, 1'b0, 8'h00, 6'h1C, 1'b0},
        '{ext_add_carry_into_mem, 8'h00, 8'h7F, 8'h00, 1'b1, 8'h80, 6'h28, 1'b0},
        '{ext_and_to_acc, 8'h00, 8'hFF, 8'h00, 1'b0, 8'h00, 6'h38, 1'b0},
        '{skip_zero_copy_to_acc, 8'h00, 8'h96, 8'h96, 1'b0, 8'h00, 6'h38, 1'b0},
        '{ext_and_into_mem, 8'h00, 8'h69, 8'h96, 1'b1, 8'h00, 6'h38, 1'b0},
        '{ext_zero_mem, 8'h00, 8'hAB, 8'h96, 1'b1, 8'h00, 6'h38, 1'b0},
        '{ext_zero_bit, 8'h03, 8'hFF, 8'h96, 1'b1, 8'hF7, 6'h38, 1'b0},
        '{ext_invert_mem, 8'h00, 8'h0F, 8'h96, 1'b1, 8'hF0, 6'h28, 1'b0},
        '{ext_invert_to_acc, 8'h00, 8'hFF, 8'h00, 1'b0, 8'h00, 6'h38, 1'b0},
        '{ext_decrement_to_acc, 8'h00, 8'h00, 8'hFF, 1'b0, 8'h00, 6'h28, 1'b0},
        '{ext_increment_mem, 8'h00, 8'hFF, 8'hFF, 1'b1, 8'h00, 6'h38, 1'b0},
        '{ext_decrement_mem, 8'h00, 8'h02, 8'hFF, 1'b1, 8'h01, 6'h28, 1'b0},
        '{ext_increment_to_acc, 8'h00, 8'h7F, 8'h80, 1'b0, 8'h00, 6'h28, 1'b0},
        '{ext_decimal_adjust, 8'h00, 8'h00, 8'h80, 1'b1, 8'h86, 6'h28, 1'b0},
        '{skip_zero_copy_to_acc, 8'h00, 8'hA0, 8'hA0, 1'b0, 8'h00, 6'h28, 1'b0},
        '{ext_decimal_adjust, 8'h00, 8'h00, 8'hA0, 1'b1, 8'h06, 6'h2C, 1'b0},
        '{skip_on_zero_mem, 8'h00, 8'h00, 8'hA0, 1'b1, 8'h00, 6'h2C, 1'b1},
        '{skip_on_zero_mem, 8'h00, 8'h11, 8'hA0, 1'b1, 8'h11, 6'h2C, 1'b0},
        '{skip_on_bit_zero, 8'h02, 8'hFB, 8'hA0, 1'b0, 8'h00, 6'h2C, 1'b1},
        '{skip_on_bit_zero, 8'h02, 8'h04, 8'hA0, 1'b0, 8'h00, 6'h2C, 1'b0},
        '{op_nop, 8'h00, 8'h55, 8'hA0, 1'b0, 8'h00, 6'h2C, 1'b0}
    };
    // ----------------------------------------
    // device, clock and hang guard
    // ----------------------------------------
    acc_alu uut (.clk(clk), .rst(rst), .op_valid(op_valid), .instr(instr),
        .bank_sel(bank_sel), .busy(busy), .skip(skip), .mem_rdata(mem_rdata),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .prog_addr(prog_addr), .prog_word(prog_word), .ptr_low_we(ptr_low_we),
        .ptr_high_we(ptr_high_we), .ptr_wdata(ptr_wdata), .acc(acc), .flags(flags),
        .table_ptr_low(tpl), .table_ptr_high(tph), .table_read_high_byte(tbh));
    initial begin
        forever #20 clk = ~clk;
    end
    // whole run is under a hundred cycles, so this ceiling only trips on a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // request, refused request in the busy cycle, then low and high bytes
    task automatic tbl(input op_t op, input logic [13:0] ea, input logic [15:0] w);
        @(posedge clk);
        op_valid <= 1'b1;
        instr <= '{op: op, imm: 8'h00, bit_sel: 3'h0, addr: 10'h010};
        prog_word <= w;
        @(posedge clk);
        instr <= '{op: subtract_imm, imm: 8'h01, bit_sel: 3'h0, addr: 10'h010};
        #1 chk("busy", 16'h1, busy);
        chk("prog_addr", ea, prog_addr);
        @(posedge clk);
        op_valid <= 1'b0;
        #1 chk("busy", 16'h0, busy);
        chk("mem_we", 16'h1, mem_we);
        chk("mem_wdata", w[7:0], mem_wdata);
        chk("high byte", w[15:8], tbh);
        chk("acc", 16'hA0, acc);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1 chk("acc", 16'h0, acc);
        chk("flags", 16'h0, flags);
        chk("busy", 16'h0, busy);
        @(posedge clk);
        op_valid <= 1'b1;
        instr <= '{op: rows[0].op, imm: rows[0].imm, bit_sel: 3'h0, addr: 10'h300};
        mem_rdata <= rows[0].rd;
        // one request per cycle, next row launched on the edge that takes this one
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            a = 10'h300 + i[9:0];
            if (i < 31) begin
                instr <= '{op: rows[i+1].op, imm: rows[i+1].imm,
                    bit_sel: rows[i+1].imm[2:0], addr: a + 10'h001};
                mem_rdata <= rows[i+1].rd;
            end else op_valid <= 1'b0;
            #1 chk(rows[i].op.name(), rows[i].acc, acc);
            chk("flags", rows[i].fl, flags);
            chk("skip", rows[i].sk, skip);
            chk("mem_we", rows[i].we, mem_we);
            if (rows[i].we) begin
                chk("mem_wdata", rows[i].wd, mem_wdata);
                if (rows[i].op >= ext_add_carry_to_acc) chk("mem_addr", a, mem_addr);
                else chk("mem_addr", {2'h1, a[7:0]}, mem_addr);
            end
        end
        $display("test of operation table done");
        @(posedge clk);
        ptr_high_we <= 1'b1;
        ptr_wdata <= 8'h12;
        @(posedge clk);
        ptr_high_we <= 1'b0;
        ptr_low_we <= 1'b1;
        ptr_wdata <= 8'hFF;
        @(posedge clk);
        ptr_low_we <= 1'b0;
        tbl(table_read_preinc_paged, 14'h1200, 16'hBEEF);
        chk("ptr low", 16'h00, tpl);
        tbl(table_read_last_page, 14'h3F00, 16'h1234);
        tbl(table_read_preinc_last_page, 14'h3F01, 16'hC35A);
        tbl(table_read_paged, 14'h1201, 16'h0FF0);
        chk("ptr high", 16'h12, tph);
        $display("test of table reads done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk("acc", 16'h0, acc);
        chk("flags", 16'h0, flags);
        chk("ptr low", 16'h0, tpl);
        chk("high byte", 16'h0, tbh);
        $display("test of reset in mid-run done");
        // first request after reset: increment to acc from ff must wrap
        @(posedge clk);
        op_valid <= 1'b1;
        instr <= '{op: ext_increment_to_acc, imm: 8'h00, bit_sel: 3'h0, addr: 10'h3FF};
        mem_rdata <= 8'hFF;
        @(posedge clk);
        op_valid <= 1'b0;
        #1 chk("wrap acc", 16'h00, acc);
        chk("wrap flags", 16'h10, flags);
        chk("wrap mem_we", 16'h0, mem_we);
        $display("test of increment wrap done");
        report_and_stop();
    end
endmodule
